// [design/ppecc_gen.sv]
// parallel port code generator: byte tap, layout control, result registers
// How it works
// - one mode bit picks two codes over 256 bytes each or one code over 512 bytes.
// - each code holds row and column parities that correct one bit and detect two.
// - with the mode bit at 0 two 3-byte codes are built, each over its own 256 bytes.
// - any write to the restart register starts a new calculation on the next bytes.
// - the first 256 bytes go to the first result and the next 256 to the second.
// - after the second code both results hold until the next restart write.
// - with the mode bit at 1 one code over 512 bytes lands in the first result only.
// - after that code the first result holds until the next restart write.
// - bytes are taken from the waveform master or the strobed slave FIFO transfers.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module ppecc_gen
  import ppecc_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // byte taps
  input  wire logic              wfm_byte_valid,
  input  wire logic [7:0]        wfm_byte_data,
  input  wire logic              fifo_byte_valid,
  input  wire logic [7:0]        fifo_byte_data,
  // status
  output logic                   code_done
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic                  mode_q;
  logic                  mode_d;
  ppecc_phase_t          ph_q;
  ppecc_phase_t          ph_d;
  logic [CNT_W-1:0]      cnt_q;
  logic [CNT_W-1:0]      cnt_d;
  logic [CODE_W-1:0]     code1_q;
  logic [CODE_W-1:0]     code1_d;
  logic [CODE_W-1:0]     code2_q;
  logic [CODE_W-1:0]     code2_d;
  logic [31:0]           rdata_q;
  logic [31:0]           rdata_d;
  logic                  restart;
  logic                  byte_ok;
  logic [7:0]            byte_in;
  logic                  take;
  logic                  last;
  logic                  clr;
  logic [CODE_W-1:0]     acc_code;
  logic [CODE_W-1:0]     fin_code;
  logic [CNT_W-1:0]      blk_end;
  logic                  cap_q;
  ppecc_phase_t          cap_ph_q;

  localparam logic [CNT_W-1:0] SMALL_END = CNT_W'(SMALL_BLOCK - 1);
  localparam logic [CNT_W-1:0] LARGE_END = CNT_W'(LARGE_BLOCK - 1);
  localparam int               SPARE_LSB = 2 * $clog2(SMALL_BLOCK);  // pair above 256-byte lines

  // ------------------------------------------------------------
  // byte selection and block tracking
  // ------------------------------------------------------------
  // either interface feeds the accumulator, waveform master first;
  // a byte in the cycle of a restart write is dropped, as are bytes while holding
  always_comb begin
    byte_ok = wfm_byte_valid | fifo_byte_valid;
    byte_in = wfm_byte_valid ? wfm_byte_data : fifo_byte_data;
    restart = reg_wr && (reg_addr == REG_RESTART);
    take    = byte_ok && !restart && (ph_q != PH_HOLD);
    blk_end = (mode_q == MODE_ONE) ? LARGE_END : SMALL_END;
    last    = take && (cnt_q == blk_end);
    clr     = restart || cap_q;
  end

  // one accumulator, 9-bit index; the top bit is always 0 in two-code mode;
  // it clears in the capture cycle, one cycle after the last byte of a block
  ppecc_parity #(
    .AW (9)
  ) u_parity (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (clr),
    .take     (take),
    .idx      (cnt_q[8:0]),
    .data     (byte_in),
    .code     (acc_code)
  );

  // ------------------------------------------------------------
  // layout control and result registers
  // ------------------------------------------------------------
  always_comb begin
    mode_d  = mode_q;
    ph_d    = ph_q;
    cnt_d   = cnt_q;
    if (reg_wr && reg_addr == REG_CTRL) mode_d = reg_wdata[CTRL_MODE_BIT];
    if (restart) begin
      ph_d  = PH_FIRST;
      cnt_d = '0;
    end else if (take) begin
      cnt_d = last ? '0 : cnt_q + CNT_W'(1);
    end
    if (last) begin
      case (ph_q)
        PH_FIRST: begin
          if (mode_q == MODE_ONE) ph_d = PH_HOLD;
          else                    ph_d = PH_SECOND;
        end
        PH_SECOND: ph_d = PH_HOLD;
        default:   ph_d = ph_q;
      endcase
    end
  end

  // mode, phase and byte counter registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q  <= MODE_RESET;
      ph_q    <= PH_FIRST;
      cnt_q   <= '0;
    end else begin
      mode_q  <= mode_d;
      ph_q    <= ph_d;
      cnt_q   <= cnt_d;
    end
  end

  // ------------------------------------------------------------
  // code capture
  // ------------------------------------------------------------
  // capture one cycle after the last byte, when the accumulator has folded it in;
  // the accumulator clears in that cycle and may already take the next block's byte
  always_comb begin
    code1_d  = code1_q;
    code2_d  = code2_q;
    fin_code = acc_code;
    // a 256-byte block leaves the top line parity pair unused, reported as ones
    if (mode_q == MODE_TWO) fin_code[SPARE_LSB +: 2] = 2'b11;
    // a restart in the capture cycle wins and the finished code is dropped
    if (cap_q && !restart && cap_ph_q == PH_FIRST)  code1_d = fin_code;
    if (cap_q && !restart && cap_ph_q == PH_SECOND) code2_d = fin_code;
  end

  // capture strobe, phase of the finished block and the two results
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cap_q    <= 1'b0;
      cap_ph_q <= PH_FIRST;
      code1_q  <= CODE_RESET;
      code2_q  <= CODE_RESET;
    end else begin
      cap_q    <= last;
      cap_ph_q <= ph_q;
      code1_q  <= code1_d;
      code2_q  <= code2_d;
    end
  end

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        rdata_d[CTRL_MODE_BIT] = mode_q;
      end else if (reg_addr == REG_CODE1) begin
        rdata_d[CODE_W-1:0] = code1_q;
      end else if (reg_addr == REG_CODE2) begin
        rdata_d[CODE_W-1:0] = code2_q;
      end else if (reg_addr == REG_STATUS) begin
        rdata_d[STAT_DONE1_BIT] = (ph_q != PH_FIRST);
        rdata_d[STAT_DONE2_BIT] = (ph_q == PH_HOLD);
        rdata_d[STAT_CNT_LSB +: CNT_W] = cnt_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) rdata_q <= 32'h0000_0000;
    else     rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;
  assign code_done = (ph_q == PH_HOLD) && !cap_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // results stand still once the codes are fixed
  a_hold_after_done: assert property (@(posedge core_clk) disable iff (rst)
    (ph_q == PH_HOLD && !cap_q && !restart) |=> $stable(code1_q) && $stable(code2_q))
    else $error("result changed while holding");
  // a restart write sends the counter and phase back to the start
  a_restart_clears: assert property (@(posedge core_clk) disable iff (rst)
    restart |=> (cnt_q == '0) && (ph_q == PH_FIRST))
    else $error("restart did not clear counter");
  // the single-code layout never touches the second result
  a_one_mode_code2: assert property (@(posedge core_clk) disable iff (rst)
    (mode_q == MODE_ONE && ph_q == PH_FIRST) |=> $stable(code2_q))
    else $error("second result written in one-code layout");
  // the 256th byte of the two-code layout ends a block
  a_small_wrap: assert property (@(posedge core_clk) disable iff (rst)
    (take && mode_q == MODE_TWO && cnt_q == SMALL_END) |=> cnt_q == '0)
    else $error("small block did not wrap at 256");
  // traffic in the hold phase moves neither the counter nor the phase
  a_hold_ignores: assert property (@(posedge core_clk) disable iff (rst)
    (ph_q == PH_HOLD && !restart) |=> $stable(cnt_q) && (ph_q == PH_HOLD))
    else $error("held block counted more bytes");
  // the 512th byte of the single-code layout ends accumulation
  a_large_wrap: assert property (@(posedge core_clk) disable iff (rst)
    (take && mode_q == MODE_ONE && cnt_q == LARGE_END) |=> (cnt_q == '0) && (ph_q == PH_HOLD))
    else $error("large block did not end at 512");
  // the first finished 256-byte code carries its spare pair as ones
  a_spare_ones: assert property (@(posedge core_clk) disable iff (rst)
    (cap_q && !restart && cap_ph_q == PH_FIRST && mode_q == MODE_TWO)
      |=> code1_q[SPARE_LSB +: 2] == 2'b11)
    else $error("spare code bits not set");
endmodule

// [design/ppecc_pkg.sv]
// package: register map, field layout and constants of the parallel port code generator
package ppecc_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] REG_CTRL    = 4'h0;  // code_block_size_select in bit 0
  localparam logic [3:0] REG_RESTART = 4'h1;  // code_restart_register, write-only
  localparam logic [3:0] REG_CODE1   = 4'h2;  // first_code_result
  localparam logic [3:0] REG_CODE2   = 4'h3;  // second_code_result
  localparam logic [3:0] REG_STATUS  = 4'h4;  // done flags and byte count
  localparam int         ADDR_W      = 4;
  // field positions
  localparam int         CTRL_MODE_BIT  = 0;
  localparam int         STAT_DONE1_BIT = 0;
  localparam int         STAT_DONE2_BIT = 1;
  localparam int         STAT_CNT_LSB   = 8;
  // block sizes and widths
  localparam int         SMALL_BLOCK  = 256;
  localparam int         LARGE_BLOCK  = 512;
  localparam int         CNT_W        = 10;
  localparam int         CODE_W       = 24;
  // reset values
  localparam logic [23:0] CODE_RESET  = 24'hff_ffff;
  localparam logic        MODE_RESET  = 1'b0;
  // layout select values
  localparam logic        MODE_TWO    = 1'b0;
  localparam logic        MODE_ONE    = 1'b1;
  // accumulation phase
  typedef enum logic [1:0] {
    PH_FIRST  = 2'b00,
    PH_SECOND = 2'b01,
    PH_HOLD   = 2'b10
  } ppecc_phase_t;
endpackage

// [design/ppecc_parity.sv]
// parity accumulator: row and column parity over one block of bytes
`timescale 1ns/1ps
module ppecc_parity
  import ppecc_pkg::*;
#(
  parameter int AW = 9  // byte index width, 8 for 256 bytes, 9 for 512 bytes
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // control
  input  wire logic          clear,
  input  wire logic          take,
  input  wire logic [AW-1:0] idx,
  input  wire logic [7:0]    data,
  // code
  output logic [CODE_W-1:0]  code
);
  logic [2*AW-1:0] row_q;
  logic [2*AW-1:0] row_d;
  logic [5:0]      col_q;
  logic [5:0]      col_d;
  logic            bp;

  // fold byte parity into the line parity pairs and bit parity into column pairs;
  // a clear together with a byte starts the new block with that byte, so none is lost
  always_comb begin
    bp    = ^data;
    row_d = row_q;
    col_d = col_q;
    if (clear) begin
      row_d = '0;
      col_d = '0;
    end
    if (take) begin
      for (int i = 0; i < AW; i++) begin
        if (idx[i]) row_d[2*i+1] = row_d[2*i+1] ^ bp;
        else        row_d[2*i]   = row_d[2*i]   ^ bp;
      end
      col_d[0] = col_d[0] ^ data[0] ^ data[2] ^ data[4] ^ data[6];
      col_d[1] = col_d[1] ^ data[1] ^ data[3] ^ data[5] ^ data[7];
      col_d[2] = col_d[2] ^ data[0] ^ data[1] ^ data[4] ^ data[5];
      col_d[3] = col_d[3] ^ data[2] ^ data[3] ^ data[6] ^ data[7];
      col_d[4] = col_d[4] ^ data[0] ^ data[1] ^ data[2] ^ data[3];
      col_d[5] = col_d[5] ^ data[4] ^ data[5] ^ data[6] ^ data[7];
    end
  end

  // parity registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      row_q <= '0;
      col_q <= '0;
    end else begin
      row_q <= row_d;
      col_q <= col_d;
    end
  end

  // inverted parities, column byte on top; with AW at 8 its two spare bits are set to one
  always_comb begin
    code = CODE_RESET;
    code[2*AW-1:0] = ~row_q;
    code[23:18]    = ~col_q;
  end
endmodule

// [test/ppecc_src.sv]
// byte source model standing on the far side of both byte taps
`timescale 1ns/1ps
module ppecc_src (
  // clock
  input  wire logic       core_clk,
  // byte taps
  output logic            wfm_byte_valid,
  output logic [7:0]      wfm_byte_data,
  output logic            fifo_byte_valid,
  output logic [7:0]      fifo_byte_data
);
  initial begin
    wfm_byte_valid  = 1'b0;
    fifo_byte_valid = 1'b0;
    wfm_byte_data   = 8'h00;
    fifo_byte_data  = 8'h00;
  end
  // one byte-wide transfer: how 0 fifo, 1 waveform, 2 both (fifo byte is junk)
  task automatic send(input logic [7:0] b, input int how, input int gap);
    @(posedge core_clk);
    wfm_byte_valid  <= (how != 0);
    fifo_byte_valid <= (how != 1);
    wfm_byte_data   <= (how != 0) ? b : ~wfm_byte_data;
    fifo_byte_data  <= (how == 0) ? b : ~b;
    // released lines show the inverse of their last value, so after a waveform or dual send the fifo line shows the byte itself
    repeat (gap) begin
      @(posedge core_clk);
      wfm_byte_valid  <= 1'b0;
      fifo_byte_valid <= 1'b0;
      wfm_byte_data   <= ~wfm_byte_data;
      fifo_byte_data  <= ~fifo_byte_data;
    end
  endtask
  // release both taps after the last byte of a burst
  task automatic idle();
    @(posedge core_clk);
    wfm_byte_valid  <= 1'b0;
    fifo_byte_valid <= 1'b0;
    wfm_byte_data   <= ~wfm_byte_data;
    fifo_byte_data  <= ~fifo_byte_data;
  endtask
endmodule

// [test/testbench.sv]
// self-checking bench for the parallel port code generator
`timescale 1ns/1ps
module testbench;
  import ppecc_pkg::*;
  logic              core_clk, rst, reg_wr, reg_rd, code_done;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata, reg_rdata;
  logic              wv, fv;
  logic [7:0]        wd, fd;
  logic [31:0]       exp_q[$];
  logic [7:0]        blk[$];
  int                fails, num_checks, seed;
  logic              rd_seen;
  logic [23:0]       code2_ref;
  ppecc_gen uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wfm_byte_valid(wv),
    .wfm_byte_data(wd), .fifo_byte_valid(fv), .fifo_byte_data(fd), .code_done(code_done));
  ppecc_src src (.core_clk(core_clk), .wfm_byte_valid(wv), .wfm_byte_data(wd),
    .fifo_byte_valid(fv), .fifo_byte_data(fd));
  // clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  // monitor: read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_seen) cmp(reg_rdata, exp_q.pop_front());
    rd_seen = reg_rd;
  end
  // reference code: inverted row pairs per index bit, then column pairs
  function automatic logic [23:0] ref_code(input int s, input int n);
    logic [23:0] p;
    p = '0;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 9; k++) p[2*k+((i>>k)&1)] ^= ^blk[s+i];
      for (int j = 0; j < 3; j++)
        for (int c = 0; c < 8; c++) p[18+2*j+((c>>j)&1)] ^= blk[s+i][c];
    end
    p = ~p;
    if (n == SMALL_BLOCK) p[17:16] = 2'b11;
    return p;
  endfunction
  // random bytes over random taps with random gaps
  task automatic bytes(input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      blk.push_back(b);
      src.send(b, int'($unsigned($random(seed)) % 3), int'($random(seed) & 1));
    end
    src.idle();
  endtask
  initial begin
    fails = 0;
    num_checks = 0;
    seed = 80;
    rd_seen = 1'b0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(REG_CODE1, {8'h00, CODE_RESET});
    rd(REG_CODE2, {8'h00, CODE_RESET});
    rd(4'hf, 32'h0000_0000);
    // two codes over 256 bytes, then extra traffic that must not disturb them
    wr(REG_RESTART, $random(seed));
    bytes(SMALL_BLOCK * 2 + 20);
    repeat (4) @(posedge core_clk);
    cmp({31'h0, code_done}, 32'h0000_0001);
    rd(REG_CODE1, {8'h00, ref_code(0, SMALL_BLOCK)});
    code2_ref = ref_code(SMALL_BLOCK, SMALL_BLOCK);
    rd(REG_CODE2, {8'h00, code2_ref});
    rd(REG_STATUS, 32'(1 << STAT_DONE1_BIT) | 32'(1 << STAT_DONE2_BIT));
    // one code over 512 bytes, restarted mid-stream
    wr(REG_CTRL, 32'h0000_0001);
    wr(REG_RESTART, $random(seed));
    @(negedge core_clk);
    cmp({31'h0, code_done}, 32'h0000_0000);
    bytes(100);
    blk.delete();
    wr(REG_RESTART, $random(seed));
    bytes(LARGE_BLOCK + 20);
    repeat (4) @(posedge core_clk);
    rd(REG_CODE1, {8'h00, ref_code(0, LARGE_BLOCK)});
    rd(REG_CODE2, {8'h00, code2_ref});
    rd(REG_CTRL, 32'h0000_0001);
    repeat (3) @(posedge core_clk);
    print_verdict();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    print_verdict();
  end
endmodule
